//--- hw/fbs_pkg.sv
// Shared constants and frame types of the fieldbus slave I/O connection block
package fbs_pkg;
	// Frame geometry
	localparam int IO_BYTES = 8;
	localparam logic [3:0] SHORT_MAX = 4'h5;
	localparam logic [3:0] HDR_LEN = 4'h2;
	localparam logic [3:0] FULL_LEN = 4'h8;
	localparam int FRAG_BIT = 7;
	localparam logic [3:0] FIRST_DATA = 4'h2;
	// Message groups and identifiers
	localparam logic [1:0] GRP1 = 2'h1;
	localparam logic [1:0] GRP2 = 2'h2;
	localparam logic [5:0] MID_EXPL = 6'h04;
	localparam logic [5:0] MID_POLL = 6'h05;
	localparam logic [5:0] MID_UNC = 6'h06;
	localparam logic [5:0] MID_POLL_RSP = 6'h0f;
	localparam logic [5:0] MID_EXPL_RSP = 6'h03;
	// Services, classes, instances, attributes
	localparam logic [7:0] SVC_GET = 8'h0e;
	localparam logic [7:0] SVC_SET = 8'h10;
	localparam logic [7:0] SVC_ALLOC = 8'h4b;
	localparam logic [7:0] SVC_REL = 8'h4c;
	localparam logic [7:0] SVC_ERR = 8'h14;
	localparam logic [7:0] RSP_BIT = 8'h80;
	localparam logic [7:0] ERR_CODE = 8'h08;
	localparam logic [7:0] CLS_DN = 8'h03;
	localparam logic [7:0] CLS_ASM = 8'h04;
	localparam logic [7:0] CLS_CONN = 8'h05;
	localparam logic [7:0] INST_EXPL = 8'h01;
	localparam logic [7:0] INST_POLL = 8'h02;
	localparam logic [7:0] ATTR_MAC = 8'h01;
	localparam logic [7:0] ATTR_BAUD = 8'h02;
	localparam logic [7:0] ATTR_IO = 8'h03;
	localparam logic [7:0] ATTR_EPR = 8'h09;
	localparam int ALLOC_EXPL = 0;
	localparam int ALLOC_POLL = 1;
	// Fragment protocol byte: type in [7:6], count in [5:0]
	localparam logic [1:0] FT_FIRST = 2'h0;
	localparam logic [1:0] FT_MID = 2'h1;
	localparam logic [1:0] FT_LAST = 2'h2;
	// Node settings
	localparam logic [5:0] MAC_DEFAULT = 6'h3f;
	localparam logic [1:0] BAUD_125K = 2'h0;
	localparam logic [1:0] BAUD_MAX = 2'h2;
	// Timing
	localparam int CLK_NS = 20;
	localparam int TICK_NS = 1000000;
	localparam int MS_CYCLES = TICK_NS / CLK_NS;
	localparam int EPR_W = 16;

	typedef struct packed {
		logic [1:0] grp;
		logic [5:0] msgid;
		logic [5:0] mac;
		logic [3:0] len;
		logic [7:0][7:0] data;
	} fbs_frame_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_SEND2 = 3'b100
	} fbs_state_t;
endpackage

//--- hw/fbs_conn_timer.sv
// Inactivity timer of one connection
`timescale 1ns/10ps
module fbs_conn_timer
	import fbs_pkg::*;
#(
	parameter int W = EPR_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Control
	input wire logic tick,
	input wire logic open,
	input wire logic reload,
	input wire logic [W-1:0] epr,
	// Status
	output logic expire
);
	logic [W-1:0] cnt_reg;
	logic run;
	logic last;

	assign run = open && tick && (epr != '0) && !reload;
	assign last = (cnt_reg == W'(1));

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_reg <= '0;
		end else if (reload) begin
			// Allocation reloads while the open flag is still low
			cnt_reg <= epr;
		end else if (!open) begin
			cnt_reg <= '0;
		end else if (run && cnt_reg != '0) begin
			cnt_reg <= cnt_reg - W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			expire <= 1'b0;
		end else begin
			expire <= run && last;
		end
	end
endmodule

//--- hw/fbs_slave.sv
// Fieldbus slave: explicit and poll connections, rack I/O, node settings
`timescale 1ns/10ps
module fbs_slave
	import fbs_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Received frames from the CAN controller
	input wire logic rx_valid,
	input wire fbs_frame_t rx_frame,
	output logic rx_ready,
	// Frames to transmit
	output logic tx_valid,
	output fbs_frame_t tx_frame,
	input wire logic tx_ready,
	// Rack input side
	input wire logic [7:0][7:0] in_data,
	input wire logic [3:0] in_len,
	// Rack output side
	input wire logic [7:0] out_mask,
	output logic [7:0][7:0] out_data,
	// Retained settings
	input wire logic stored_valid,
	input wire logic [5:0] stored_mac,
	input wire logic [1:0] stored_baud,
	output logic [5:0] node_addr,
	output logic [1:0] baud_sel,
	// Connection status
	output logic expl_open,
	output logic poll_open
);
	fbs_state_t state_reg, state_next;
	fbs_frame_t frag2_reg, tx_next, frag2_next;
	logic [7:0][7:0] asm_reg, asm_next, out_next, out_new;
	logic [3:0] asm_idx_reg, asm_idx_next;
	logic [EPR_W-1:0] epr_e_reg, epr_p_reg;
	logic [$clog2(MS_DIV)-1:0] div_reg;
	logic tick_reg, boot_reg, exp_e, exp_p;
	logic hit, is_expl, is_poll, is_unc, frag, alloc, release_cmd, tx_done;
	logic rd_in, wr_out1, wr_outf, set_epr, set_mac, set_baud, known, apply_out;
	logic [7:0] svc, cls, inst, attr, hdr;
	logic [1:0] ftype;
	logic [1:0] choice;
	logic rel_e, rel_p, any_rel;
	logic [7:0] new_valid;

	// Millisecond tick from the module clock
	always_ff @(posedge mclk) begin
		if (srst || div_reg == ($clog2(MS_DIV))'(MS_DIV - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
		tick_reg <= !srst && div_reg == ($clog2(MS_DIV))'(MS_DIV - 1);
	end

	// Frame field decode
	assign hdr = rx_frame.data[0];
	assign frag = hdr[FRAG_BIT];
	assign ftype = rx_frame.data[1][7:6];
	assign svc = rx_frame.data[1];
	assign cls = rx_frame.data[2];
	assign inst = rx_frame.data[3];
	assign attr = rx_frame.data[4];
	assign choice = rx_frame.data[4][1:0];
	assign hit = rx_valid && rx_ready && rx_frame.mac == node_addr;
	assign is_expl = hit && rx_frame.grp == GRP2 && rx_frame.msgid == MID_EXPL && expl_open;
	assign is_poll = hit && rx_frame.grp == GRP2 && rx_frame.msgid == MID_POLL && poll_open;
	assign is_unc = hit && rx_frame.grp == GRP2 && rx_frame.msgid == MID_UNC;
	assign alloc = is_unc && svc == SVC_ALLOC && cls == CLS_DN && inst == INST_EXPL;
	assign release_cmd = is_unc && svc == SVC_REL && cls == CLS_DN && inst == INST_EXPL;

	// Explicit services
	assign rd_in = is_expl && !frag && svc == SVC_GET && cls == CLS_ASM
		&& inst == INST_EXPL && attr == ATTR_IO;
	assign wr_out1 = is_expl && !frag && svc == SVC_SET && cls == CLS_ASM
		&& inst == INST_EXPL && attr == ATTR_IO;
	// fragmented output write, finished on last piece
	assign wr_outf = is_expl && frag && ftype == FT_LAST;
	assign set_epr = is_expl && !frag && svc == SVC_SET && cls == CLS_CONN
		&& (inst == INST_EXPL || inst == INST_POLL) && attr == ATTR_EPR;
	assign set_mac = is_expl && !frag && svc == SVC_SET && cls == CLS_DN
		&& inst == INST_EXPL && attr == ATTR_MAC;
	assign set_baud = is_expl && !frag && svc == SVC_SET && cls == CLS_DN
		&& inst == INST_EXPL && attr == ATTR_BAUD && rx_frame.data[5][1:0] <= BAUD_MAX;
	assign known = rd_in || wr_out1 || frag || set_epr || set_mac || set_baud;
	assign tx_done = tx_valid && tx_ready;

	// Releases by command or inactivity
	assign rel_e = (release_cmd && choice[ALLOC_EXPL]) || exp_e;
	assign rel_p = (release_cmd && choice[ALLOC_POLL]) || exp_p;
	assign any_rel = rel_e || rel_p;

	// Output bytes: short write, fragment assembly or poll data, limited by count
	assign out_new = is_poll ? rx_frame.data : (wr_outf ? asm_next : {rx_frame.data[7:5],
		rx_frame.data[7:5], rx_frame.data[7:6]});
	assign apply_out = is_poll || wr_outf || wr_out1;
	genvar gi;
	generate
		for (gi = 0; gi < IO_BYTES; gi++) begin : g_out
			// bytes beyond the received count are written as zero
			assign new_valid[gi] = is_poll ? (4'(gi) < rx_frame.len)
				: (wr_outf ? (4'(gi) < asm_idx_next)
				: (4'(gi) + SHORT_MAX < rx_frame.len));
			// drop bytes of empty or input slots
			assign out_next[gi] = (out_mask[gi] && new_valid[gi])
				? (wr_out1 ? rx_frame.data[5 + gi % 3] : out_new[gi]) : 8'h00;
		end
	endgenerate

	// Fragment assembly and reply building
	always_comb begin
		state_next = state_reg;
		tx_next = tx_frame;
		frag2_next = frag2_reg;
		asm_next = asm_reg;
		asm_idx_next = asm_idx_reg;
		if (is_expl && frag) begin
			if (ftype == FT_FIRST) begin
				asm_next = '0;
				asm_next[0] = rx_frame.data[6];
				asm_next[1] = rx_frame.data[7];
				asm_idx_next = FIRST_DATA;
			end else begin
				for (int j = 0; j < 6; j++) begin
					if (32'(asm_idx_reg) + j < IO_BYTES && j + 2 < 32'(rx_frame.len)) begin
						asm_next[3'(32'(asm_idx_reg) + j)] = rx_frame.data[j + 2];
					end
				end
				asm_idx_next = (asm_idx_reg + rx_frame.len - HDR_LEN > FULL_LEN) ? FULL_LEN
					: 4'(asm_idx_reg + rx_frame.len - HDR_LEN);
			end
		end
		case (state_reg)
			ST_IDLE: begin
				tx_next = '0;
				tx_next.grp = GRP1;
				tx_next.msgid = MID_EXPL_RSP;
				tx_next.mac = node_addr;
				tx_next.data[0] = {1'b0, hdr[6:0]};
				if (is_poll) begin
					tx_next.msgid = MID_POLL_RSP;
					tx_next.data = in_data;
					tx_next.len = in_len;
					state_next = ST_SEND;
				end else if (rd_in && in_len > SHORT_MAX) begin
					tx_next.data[0][FRAG_BIT] = 1'b1;
					tx_next.data[1] = {FT_FIRST, 6'h00};
					tx_next.data[2] = svc | RSP_BIT;
					for (int j = 0; j < 5; j++) tx_next.data[j + 3] = in_data[j];
					tx_next.len = FULL_LEN;
					frag2_next = tx_next;
					frag2_next.data = '0;
					frag2_next.data[0] = tx_next.data[0];
					frag2_next.data[1] = {FT_LAST, 6'h01};
					for (int j = 0; j < 3; j++) frag2_next.data[j + 2] = in_data[j + 5];
					frag2_next.len = 4'(in_len - SHORT_MAX + HDR_LEN);
					state_next = ST_SEND2;
				end else if (rd_in) begin
					// short reply carries exactly the input count
					tx_next.data[1] = svc | RSP_BIT;
					for (int j = 0; j < 5; j++) tx_next.data[j + 2] = in_data[j];
					tx_next.len = 4'(in_len + HDR_LEN);
					state_next = ST_SEND;
				end else if (alloc || release_cmd || wr_outf
					|| (is_expl && !frag && known)) begin
					// Last fragment holds the fragment byte where the service sat
					tx_next.data[1] = (wr_outf ? SVC_SET : svc) | RSP_BIT;
					tx_next.len = HDR_LEN;
					state_next = ST_SEND;
				end else if (is_expl && !frag) begin
					// Unsupported request answered with an error reply
					tx_next.data[1] = SVC_ERR | RSP_BIT;
					tx_next.data[2] = ERR_CODE;
					tx_next.len = HDR_LEN + 4'h1;
					state_next = ST_SEND;
				end
			end
			ST_SEND2: begin
				if (tx_ready) begin
					tx_next = frag2_reg;
					state_next = ST_SEND;
				end
			end
			ST_SEND: begin
				if (tx_ready) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Reply sequencer; receive is held off while a reply waits
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			tx_valid <= 1'b0;
			tx_frame <= '0;
			frag2_reg <= '0;
			asm_reg <= '0;
			asm_idx_reg <= '0;
			rx_ready <= 1'b0;
		end else begin
			state_reg <= state_next;
			tx_valid <= state_next != ST_IDLE && !(state_reg == ST_SEND && tx_done);
			tx_frame <= tx_next;
			frag2_reg <= frag2_next;
			asm_reg <= asm_next;
			asm_idx_reg <= asm_idx_next;
			rx_ready <= state_next == ST_IDLE;
		end
	end

	// Connection state and outputs
	always_ff @(posedge mclk) begin
		if (srst) begin
			expl_open <= 1'b0;
			poll_open <= 1'b0;
			out_data <= '0;
			epr_e_reg <= '0;
			epr_p_reg <= '0;
		end else begin
			// each connection allocated on its own or together
			expl_open <= (expl_open && !rel_e) || (alloc && choice[ALLOC_EXPL]);
			poll_open <= (poll_open && !rel_p) || (alloc && choice[ALLOC_POLL]);
			if (any_rel) begin
				out_data <= '0;
			end else if (apply_out) begin
				out_data <= out_next;
			end
			if (set_epr && inst == INST_EXPL) begin
				epr_e_reg <= {rx_frame.data[6], rx_frame.data[5]};
			end
			if (set_epr && inst == INST_POLL) begin
				epr_p_reg <= {rx_frame.data[6], rx_frame.data[5]};
			end
		end
	end

	// Node address and baud: defaults, then retained values after reset release
	always_ff @(posedge mclk) begin
		if (srst) begin
			node_addr <= MAC_DEFAULT;
			baud_sel <= BAUD_125K;
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
			if (boot_reg && stored_valid) begin
				node_addr <= stored_mac;
				baud_sel <= stored_baud;
			end else if (set_mac) begin
				// six bits keep the address in 0-63
				node_addr <= rx_frame.data[5][5:0];
			end else if (set_baud) begin
				baud_sel <= rx_frame.data[5][1:0];
			end
		end
	end

	fbs_conn_timer #(.W(EPR_W)) u_tmr_expl (
		.mclk(mclk),
		.srst(srst),
		.tick(tick_reg),
		.open(expl_open),
		.reload(is_expl || (alloc && choice[ALLOC_EXPL])),
		.epr(epr_e_reg),
		.expire(exp_e)
	);

	fbs_conn_timer #(.W(EPR_W)) u_tmr_poll (
		.mclk(mclk),
		.srst(srst),
		.tick(tick_reg),
		.open(poll_open),
		.reload(is_poll || (alloc && choice[ALLOC_POLL]) || (set_epr && inst == INST_POLL)),
		.epr(epr_p_reg),
		.expire(exp_p)
	);
endmodule

//--- sim/fbs_slave_asserts.sv
// Port-level checks of the fieldbus slave
`timescale 1ns/10ps
module fbs_slave_asserts
	import fbs_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Frame link
	input wire logic rx_valid,
	input wire fbs_frame_t rx_frame,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire fbs_frame_t tx_frame,
	input wire logic tx_ready,
	// Rack and node state
	input wire logic [7:0][7:0] in_data,
	input wire logic [3:0] in_len,
	input wire logic [7:0][7:0] out_data,
	input wire logic [5:0] node_addr,
	input wire logic [1:0] baud_sel,
	input wire logic expl_open,
	input wire logic poll_open
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Frames taken by this node; a poll counts only on an open poll connection
	wire logic take = rx_valid && rx_ready && rx_frame.mac == node_addr;
	wire logic poll_take = take && rx_frame.grp == GRP2 && rx_frame.msgid == MID_POLL && poll_open;

	a_reply_needs_take: assert property ($rose(tx_valid) |-> !rx_ready && $past(take))
		else $error("reply raised while receiver idle");
	a_poll_reply_form: assert property (poll_take |=> tx_valid && tx_frame.grp == GRP1
		&& tx_frame.msgid == MID_POLL_RSP && !rx_ready) else $error("poll reply malformed");
	a_poll_reply_data: assert property (poll_take |=> tx_frame.data == $past(in_data)
		&& tx_frame.len == $past(in_len)) else $error("poll reply data wrong");
	a_reset_settings: assert property ($fell(srst) |-> node_addr == MAC_DEFAULT
		&& baud_sel == BAUD_125K && !expl_open && !poll_open) else $error("bad reset state");
	a_release_clears_out: assert property ($fell(poll_open) || $fell(expl_open)
		|-> ##[0:1] out_data == '0) else $error("outputs kept after release");
	a_foreign_dropped: assert property (rx_valid && rx_ready && rx_frame.mac != node_addr
		|=> !tx_valid) else $error("answered foreign frame");
	a_open_by_command: assert property ($rose(expl_open) || $rose(poll_open)
		|-> $past(rx_valid && rx_ready && rx_frame.msgid == MID_UNC)) else $error("bad open");
	a_reply_holds: assert property (tx_valid && !tx_ready |=> tx_valid
		&& $stable(tx_frame)) else $error("reply dropped before accept");

	// Main scenarios reached
	c_poll: cover property (poll_take);
	c_release: cover property ($fell(poll_open));
	c_fragment: cover property (tx_valid && tx_frame.data[0][FRAG_BIT]);
endmodule

bind fbs_slave fbs_slave_asserts #(.MS_DIV(MS_DIV)) u_chk (.mclk(mclk), .srst(srst),
	.rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready), .tx_valid(tx_valid),
	.tx_frame(tx_frame), .tx_ready(tx_ready), .in_data(in_data), .in_len(in_len),
	.out_data(out_data), .node_addr(node_addr), .baud_sel(baud_sel),
	.expl_open(expl_open), .poll_open(poll_open));

//--- sim/fbs_master_model.sv
// Behavioural network master and CAN controller facing the slave
`timescale 1ns/10ps
module fbs_master_model
	import fbs_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Bench control
	input wire logic go,
	input wire fbs_frame_t frame_in,
	input wire logic slow,
	// Slave side
	output logic rx_valid,
	output fbs_frame_t rx_frame,
	input wire logic rx_ready,
	output logic tx_ready
);
	logic [1:0] stall_reg;
	// one request held until the slave takes it
	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_valid <= 1'b0;
			rx_frame <= '1;
		end else if (rx_valid && rx_ready) begin
			rx_valid <= 1'b0;
			rx_frame <= ~rx_frame; // Idle bus must not look like the last frame
		end else if (go) begin
			rx_valid <= 1'b1;
			rx_frame <= frame_in;
		end
	end
	// A slow controller accepts only one cycle in four
	always_ff @(posedge mclk) begin
		stall_reg <= srst ? 2'h0 : stall_reg + 2'h1;
		tx_ready <= !slow || stall_reg == 2'h3;
	end
endmodule

//--- sim/fbs_slave_tb_top.sv
// Self-checking bench of the fieldbus slave
`timescale 1ns/10ps
module fbs_slave_tb_top;
	import fbs_pkg::*;
	localparam int DIV = 10;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic go = 1'b0;
	logic slow = 1'b0;
	fbs_frame_t frame_in = '0;
	logic [7:0][7:0] in_data = '0;
	logic [3:0] in_len = 4'h0;
	logic [7:0] out_mask = 8'h00;
	logic stored_valid = 1'b0;
	logic [5:0] stored_mac = 6'h00;
	logic [1:0] stored_baud = 2'h0;
	logic rx_valid, rx_ready, tx_valid, tx_ready, expl_open, poll_open;
	fbs_frame_t rx_frame, tx_frame;
	logic [7:0][7:0] out_data;
	logic [5:0] node_addr;
	logic [1:0] baud_sel;
	logic [5:0] node_mac = MAC_DEFAULT;
	int errors = 0;
	int n_compared = 0;
	int seed = 23876;
	fbs_frame_t rr [2];
	bit got;

	always #10 mclk = ~mclk;

	fbs_slave #(.MS_DIV(DIV)) i_dut (.mclk(mclk), .srst(srst), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
		.tx_ready(tx_ready), .in_data(in_data), .in_len(in_len), .out_mask(out_mask),
		.out_data(out_data), .stored_valid(stored_valid), .stored_mac(stored_mac),
		.stored_baud(stored_baud), .node_addr(node_addr), .baud_sel(baud_sel),
		.expl_open(expl_open), .poll_open(poll_open));
	fbs_master_model i_master (.mclk(mclk), .srst(srst), .go(go), .frame_in(frame_in),
		.slow(slow), .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
		.tx_ready(tx_ready));

	// Compare and count
	task automatic chk(input logic [79:0] seen, input logic [79:0] want);
		n_compared++;
		if (seen !== want) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	function automatic fbs_frame_t cmd(logic [5:0] id, logic [3:0] n, logic [7:0] s, c, i, a,
		logic [15:0] v);
		cmd = '{grp: GRP2, msgid: id, mac: node_mac, len: n, data: {8'h00, v, a, i, c, s, 8'h00}};
	endfunction

	// Data index of input byte i in a read reply of n bytes
	function automatic int rd_pos(int n, int i);
		return n <= 5 ? i + 2 : (i < 5 ? i + 3 : i - 3);
	endfunction

	function automatic logic [63:0] masked(logic [63:0] d, logic [7:0] m);
		for (int i = 0; i < 8; i++) masked[i*8 +: 8] = m[i] ? d[i*8 +: 8] : 8'h00;
	endfunction

	// Offer one frame, then collect up to nrep replies, waiting up to 60 cycles for each
	task automatic xact(input fbs_frame_t f, input int nrep);
		@(posedge mclk);
		frame_in <= f;
		go <= 1'b1;
		slow <= 1'($random(seed));
		@(posedge mclk);
		go <= 1'b0;
		for (int k = 0; k < nrep; k++) begin
			got = 0;
			for (int w = 0; w < 60 && !got; w++) begin
				@(posedge mclk);
				if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
					rr[k] = tx_frame;
					got = 1;
				end
			end
		end
	endtask

	task automatic ack(input logic [7:0] svc);
		chk({got, rr[0].len, rr[0].data[1]}, {1'b1, HDR_LEN, svc | RSP_BIT});
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Cut a hang short well beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		finish_test();
	end

	initial begin
		logic [63:0] d;
		logic [5:0] m;
		fbs_frame_t f;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({node_addr, baud_sel}, {MAC_DEFAULT, BAUD_125K});
		// poll on a closed connection is dropped
		xact(cmd(MID_POLL, FULL_LEN, 8'h1, 8'h2, 8'h3, 8'h4, 16'h5), 1);
		chk(got, 1'b0);
		xact(cmd(MID_UNC, 4'h5, SVC_ALLOC, CLS_DN, INST_EXPL, 8'h03, 16'h0), 1);
		ack(SVC_ALLOC);
		chk({expl_open, poll_open}, 2'b11);
		// read every input count, fragmented above five
		for (int n = 0; n <= IO_BYTES; n++) begin
			in_data <= {$random(seed), $random(seed)};
			in_len <= 4'(n);
			xact(cmd(MID_EXPL, 4'h5, SVC_GET, CLS_ASM, 8'h01, ATTR_IO, 16'h0), n > 5 ? 2 : 1);
			chk({got, rr[0].len, rr[0].data[n > 5 ? 2 : 1]},
				{1'b1, n > 5 ? FULL_LEN : 4'(n + 2), SVC_GET | RSP_BIT});
			if (n > 5) chk({rr[0].data[0][7], rr[1].data[0][7], rr[1].len}, {2'b11, 4'(n - 3)});
			for (int i = 0; i < n; i++) chk(rr[i > 4 && n > 5].data[rd_pos(n, i)], in_data[i]);
		end
		repeat (6) begin
			d = {$random(seed), $random(seed)};
			in_data <= {$random(seed), $random(seed)};
			in_len <= 4'($unsigned($random(seed)) % 9);
			out_mask <= 8'($random(seed)) | 8'h81;
			xact(cmd(MID_POLL, FULL_LEN, d[15:8], d[23:16], d[31:24], d[39:32], d[55:40]), 1);
			d[7:0] = 8'h00;
			d[63:56] = 8'h00;
			chk({got, rr[0].grp, rr[0].msgid, rr[0].len}, {1'b1, GRP1, MID_POLL_RSP, in_len});
			chk(rr[0].data, in_data);
			chk(out_data, masked(d, out_mask));
		end
		// output writes: short form, then a first and a last fragment
		d = {$random(seed), $random(seed)};
		f = cmd(MID_EXPL, FULL_LEN, SVC_SET, CLS_ASM, INST_EXPL, ATTR_IO, d[15:0]);
		f.data[7] = d[23:16];
		xact(f, 1);
		ack(SVC_SET);
		chk(out_data, masked({40'h0, d[23:0]}, out_mask));
		f.data = {d[15:0], ATTR_IO, INST_EXPL, CLS_ASM, SVC_SET, FT_FIRST, 6'h00, 8'h80};
		xact(f, 0);
		f.data = {d[63:16], FT_LAST, 6'h01, 8'h80};
		xact(f, 1);
		ack(SVC_SET);
		chk(out_data, masked(d, out_mask));
		// master release of the poll connection alone
		xact(cmd(MID_UNC, 4'h5, SVC_REL, CLS_DN, INST_EXPL, 8'h02, 16'h0), 1);
		ack(SVC_REL);
		chk({expl_open, poll_open, out_data}, {2'b10, 64'h0});
		// poll expires after three ticks, explicit with rate zero stays
		xact(cmd(MID_UNC, 4'h5, SVC_ALLOC, CLS_DN, INST_EXPL, 8'h02, 16'h0), 1);
		xact(cmd(MID_EXPL, 4'h7, SVC_SET, CLS_CONN, INST_POLL, ATTR_EPR, 16'h0003), 1);
		ack(SVC_SET);
		// a rate of two, then zero, must still keep the explicit connection
		xact(cmd(MID_EXPL, 4'h7, SVC_SET, CLS_CONN, INST_EXPL, ATTR_EPR, 16'h0002), 1);
		xact(cmd(MID_EXPL, 4'h7, SVC_SET, CLS_CONN, INST_EXPL, ATTR_EPR, 16'h0000), 1);
		ack(SVC_SET);
		xact(cmd(MID_POLL, FULL_LEN, 8'hff, 8'hff, 8'hff, 8'hff, 16'hffff), 1);
		repeat (DIV / 2) @(posedge mclk);
		chk(poll_open, 1'b1);
		repeat (DIV * 4) @(posedge mclk);
		chk({expl_open, poll_open, out_data}, {2'b10, 64'h0});
		// new address; the old one is no longer answered
		m = 6'($unsigned($random(seed)) % 63);
		xact(cmd(MID_EXPL, 4'h6, SVC_SET, CLS_DN, INST_EXPL, ATTR_MAC, {10'h0, m}), 1);
		ack(SVC_SET);
		node_mac = m;
		chk(node_addr, m);
		f = cmd(MID_EXPL, 4'h5, SVC_GET, CLS_ASM, 8'h01, ATTR_IO, 16'h0);
		f.mac = MAC_DEFAULT;
		xact(f, 1);
		chk(got, 1'b0);
		// every rate code, the unknown one refused
		for (int b = 0; b < 4; b++) begin
			xact(cmd(MID_EXPL, 4'h6, SVC_SET, CLS_DN, INST_EXPL, ATTR_BAUD, 16'(b)), 1);
			if (b <= 2) begin
				chk({rr[0].len, rr[0].data[1], baud_sel},
					{HDR_LEN, SVC_SET | RSP_BIT, 2'(b)});
			end else begin
				chk({rr[0].len, rr[0].data[2:1], baud_sel},
					{4'h3, ERR_CODE, SVC_ERR | RSP_BIT, BAUD_MAX});
			end
		end
		// retained settings come back after a mid-run reset
		stored_mac <= m;
		stored_baud <= BAUD_MAX;
		stored_valid <= 1'b1;
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(node_addr, m);
		chk({baud_sel, expl_open}, {BAUD_MAX, 1'b0});
		finish_test();
	end
endmodule
